// ==== line_jitter_pkg.sv ====
// Constants, types and helper functions shared by the line channel configuration block.
//
// Function
// - Writing a one to the soft-reset bit of a channel starts a reset of that channel alone.
// - A channel soft reset ends within one microsecond of its start.
// - The soft-reset bit clears itself when its reset has ended.
// - The line-standard bit counts only while the hardware standard pin-mode input is low.
// - A line-standard value of zero selects T1/J1 and one selects E1, with zero after reset.
// - The line-standard bit survives a channel soft reset while the rest of the channel is cleared.
// - The channel registers repeat for 22 channels, channels 1 to 21 at a 0x40 stride and channel 0 at 0x7C0.
// - The receive attenuator runs only while its enable bit is one, and it is off after reset.
// - With receive fill limiting on, the receive output rate is adjusted when its FIFO is within two bits of full or empty.
// - The receive depth field gives 128 bits for 00, 64 bits for 01 and 32 bits for 1X.
// - The receive bandwidth bit picks 5 Hz or 6.77 Hz when zero and 1.26 Hz or 0.87 Hz when one, for T1/J1 or E1.
// - The transmit attenuator runs only while its enable bit is one, and it is off after reset.
// - With transmit fill limiting on, the transmit output rate is adjusted when its FIFO is within two bits of full or empty.
// - The transmit depth field gives 128 bits for 00, 64 bits for 01 and 32 bits for 1X.
// - The transmit bandwidth bit picks 5 Hz or 6.77 Hz when zero and 1.26 Hz for T1/J1 when one.
// - The one-second timer status flag sits in bit 0 of a global register whose other bits read zero.
package line_jitter_pkg;

	localparam int NUM_CHAN = 22;
	localparam int ADDR_W = 13;
	localparam int IDX_W = 11;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] CHAN0_BASE_IDX = 11'h7C0;
	localparam logic [5:0] REG_CFG_IDX = 6'h01;
	localparam logic [5:0] REG_TXA_IDX = 6'h02;
	localparam logic [5:0] REG_RXA_IDX = 6'h03;
	localparam logic [4:0] LAST_STRIDE_SLOT = 5'h14;
	localparam logic [IDX_W-1:0] TIMER_STAT_IDX = 11'h3C0;
	localparam logic [IDX_W-1:0] TIMER_MASK_IDX = 11'h3E0;

	////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values.
	localparam int CFG_STD_BIT = 0;
	localparam int CFG_SRST_BIT = 1;
	localparam int ATT_BW_BIT = 0;
	localparam int ATT_DP_LSB = 1;
	localparam int ATT_EN_BIT = 3;
	localparam int ATT_LIMIT_BIT = 4;
	localparam int ATT_FIELD_W = 5;
	localparam int TIMER_FLAG_BIT = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [ATT_FIELD_W-1:0] ATT_RESET = 5'h00;

	////////////////////////////////////////////////////////////////////////////
	// Timing: the soft reset is a longest time, so the count rounds down.
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SRST_TIME_PS = 1000000;
	localparam int SRST_CNT_W = 8;
	localparam logic [SRST_CNT_W-1:0] SRST_CYCLES = SRST_CNT_W'(SRST_TIME_PS / CLK_PERIOD_PS);

	////////////////////////////////////////////////////////////////////////////
	// Attenuator FIFO depths and the fill margin.
	localparam int FILL_W = 8;
	localparam logic [FILL_W-1:0] DEPTH_128 = 8'h80;
	localparam logic [FILL_W-1:0] DEPTH_64 = 8'h40;
	localparam logic [FILL_W-1:0] DEPTH_32 = 8'h20;
	localparam logic [FILL_W-1:0] FILL_MARGIN = 8'h02;

	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CORNER_5HZ = 2'h0,
		CORNER_6P77HZ = 2'h1,
		CORNER_1P26HZ = 2'h2,
		CORNER_0P87HZ = 2'h3
	} corner_e;

	typedef enum logic [1:0] {
		RATE_HOLD = 2'h0,
		RATE_SLOW = 2'h1,
		RATE_FAST = 2'h2
	} rate_e;

	typedef struct packed {
		logic enable;
		logic fill_limit;
		logic [FILL_W-1:0] depth_bits;
		corner_e corner;
	} atten_cfg_s;

	typedef struct packed {
		logic hit_chan;
		logic [4:0] chan;
		logic [1:0] reg_sel;
		logic hit_stat;
		logic hit_mask;
	} addr_dec_s;

	function automatic addr_dec_s decode(input logic [ADDR_W-1:0] addr);
		logic [IDX_W-1:0] idx;
		addr_dec_s d;
		idx = addr[ADDR_W-1:2];
		d = '0;
		d.hit_stat = (idx == TIMER_STAT_IDX);
		d.hit_mask = (idx == TIMER_MASK_IDX);
		d.reg_sel = idx[1:0];
		if (idx[5:0] >= REG_CFG_IDX && idx[5:0] <= REG_RXA_IDX)
		begin
			if (idx[10:6] == CHAN0_BASE_IDX[10:6])
			begin
				d.hit_chan = 1'b1;
				d.chan = 5'h00;
			end
			else if (idx[10:6] <= LAST_STRIDE_SLOT)
			begin
				d.hit_chan = 1'b1;
				d.chan = idx[10:6] + 5'h01;
			end
		end
		return d;
	endfunction

	function automatic atten_cfg_s atten_cfg(input logic [ATT_FIELD_W-1:0] raw, input logic e1);
		atten_cfg_s c;
		c = '0;
		c.enable = raw[ATT_EN_BIT];
		if (raw[ATT_EN_BIT])
		begin
			c.fill_limit = raw[ATT_LIMIT_BIT];
			if (raw[ATT_DP_LSB+1])
				c.depth_bits = DEPTH_32;
			else if (raw[ATT_DP_LSB])
				c.depth_bits = DEPTH_64;
			else
				c.depth_bits = DEPTH_128;
			case ({raw[ATT_BW_BIT], e1})
				2'b00: c.corner = CORNER_5HZ;
				2'b01: c.corner = CORNER_6P77HZ;
				2'b10: c.corner = CORNER_1P26HZ;
				default: c.corner = CORNER_0P87HZ;
			endcase
		end
		return c;
	endfunction

	// Fill at or beyond depth minus the margin drains faster; fill at or below the margin drains slower.
	function automatic rate_e rate_adjust(input atten_cfg_s c, input logic [FILL_W-1:0] fill);
		rate_e r;
		r = RATE_HOLD;
		if (c.enable && c.fill_limit)
		begin
			if (fill >= c.depth_bits - FILL_MARGIN)
				r = RATE_FAST;
			else if (fill <= FILL_MARGIN)
				r = RATE_SLOW;
		end
		return r;
	endfunction

endpackage

// ==== line_sync3.sv ====
// Three-stage synchroniser that accepts a new level once the last two stages agree.
`timescale 1ns/1ps
module line_sync3 #(
	parameter int WIDTH = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] out_r;
	logic [WIDTH-1:0] out_nxt;

	always_comb
	begin
		out_nxt = out_r;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s2_r[i] == s3_r[i])
				out_nxt[i] = s3_r[i];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			out_r <= '0;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign sync_out = out_r;

endmodule

// ==== line_chan_slice.sv ====
// Configuration registers, soft reset and attenuator controls of one line channel.
`timescale 1ns/1ps
module line_chan_slice (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_stb,
	input wire logic [1:0] wr_reg,
	input wire logic [7:0] wr_data,
	input wire logic pin_mode,
	input wire logic pin_standard,
	input wire logic [line_jitter_pkg::FILL_W-1:0] rx_fill,
	input wire logic [line_jitter_pkg::FILL_W-1:0] tx_fill,
	output logic [7:0] cfg_rd,
	output logic [7:0] txa_rd,
	output logic [7:0] rxa_rd,
	output logic chan_reset,
	output logic line_standard,
	output line_jitter_pkg::atten_cfg_s rx_cfg,
	output line_jitter_pkg::atten_cfg_s tx_cfg,
	output line_jitter_pkg::rate_e rx_rate,
	output line_jitter_pkg::rate_e tx_rate
);

	logic line_std_r;
	logic line_std_nxt;
	logic busy_r;
	logic busy_nxt;
	logic [line_jitter_pkg::SRST_CNT_W-1:0] cnt_r;
	logic [line_jitter_pkg::SRST_CNT_W-1:0] cnt_nxt;
	logic [line_jitter_pkg::ATT_FIELD_W-1:0] txa_r;
	logic [line_jitter_pkg::ATT_FIELD_W-1:0] txa_nxt;
	logic [line_jitter_pkg::ATT_FIELD_W-1:0] rxa_r;
	logic [line_jitter_pkg::ATT_FIELD_W-1:0] rxa_nxt;
	logic std_eff_r;
	logic std_eff_nxt;
	line_jitter_pkg::atten_cfg_s rx_cfg_r;
	line_jitter_pkg::atten_cfg_s rx_cfg_nxt;
	line_jitter_pkg::atten_cfg_s tx_cfg_r;
	line_jitter_pkg::atten_cfg_s tx_cfg_nxt;
	line_jitter_pkg::rate_e rx_rate_r;
	line_jitter_pkg::rate_e rx_rate_nxt;
	line_jitter_pkg::rate_e tx_rate_r;
	line_jitter_pkg::rate_e tx_rate_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Register state and the soft-reset countdown.
	always_comb
	begin
		line_std_nxt = line_std_r;
		busy_nxt = busy_r;
		cnt_nxt = cnt_r;
		txa_nxt = txa_r;
		rxa_nxt = rxa_r;
		if (busy_r)
		begin
			// Channel state is held clear for the whole reset, but the standard bit is left alone.
			txa_nxt = line_jitter_pkg::ATT_RESET;
			rxa_nxt = line_jitter_pkg::ATT_RESET;
			cnt_nxt = cnt_r - 1'b1;
			if (cnt_r == 1'b1)
				busy_nxt = 1'b0;
		end
		if (wr_stb)
		begin
			case (wr_reg)
				line_jitter_pkg::REG_CFG_IDX[1:0]:
				begin
					line_std_nxt = wr_data[line_jitter_pkg::CFG_STD_BIT];
					if (wr_data[line_jitter_pkg::CFG_SRST_BIT])
					begin
						busy_nxt = 1'b1;
						cnt_nxt = line_jitter_pkg::SRST_CYCLES;
					end
				end
				// Writes landing during a soft reset are dropped, since the reset owns these fields.
				line_jitter_pkg::REG_TXA_IDX[1:0]:
					if (!busy_r)
						txa_nxt = wr_data[line_jitter_pkg::ATT_FIELD_W-1:0];
				line_jitter_pkg::REG_RXA_IDX[1:0]:
					if (!busy_r)
						rxa_nxt = wr_data[line_jitter_pkg::ATT_FIELD_W-1:0];
				default:
				begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Effective settings seen by the datapath.
	always_comb
	begin
		std_eff_nxt = pin_mode ? pin_standard : line_std_r;
		rx_cfg_nxt = line_jitter_pkg::atten_cfg(rxa_r, std_eff_r);
		tx_cfg_nxt = line_jitter_pkg::atten_cfg(txa_r, std_eff_r);
		rx_rate_nxt = line_jitter_pkg::rate_adjust(rx_cfg_r, rx_fill);
		tx_rate_nxt = line_jitter_pkg::rate_adjust(tx_cfg_r, tx_fill);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			line_std_r <= line_jitter_pkg::CFG_RESET[line_jitter_pkg::CFG_STD_BIT];
			busy_r <= 1'b0;
			cnt_r <= '0;
			txa_r <= line_jitter_pkg::ATT_RESET;
			rxa_r <= line_jitter_pkg::ATT_RESET;
			std_eff_r <= 1'b0;
			rx_cfg_r <= '0;
			tx_cfg_r <= '0;
			rx_rate_r <= line_jitter_pkg::RATE_HOLD;
			tx_rate_r <= line_jitter_pkg::RATE_HOLD;
		end
		else
		begin
			line_std_r <= line_std_nxt;
			busy_r <= busy_nxt;
			cnt_r <= cnt_nxt;
			txa_r <= txa_nxt;
			rxa_r <= rxa_nxt;
			std_eff_r <= std_eff_nxt;
			rx_cfg_r <= rx_cfg_nxt;
			tx_cfg_r <= tx_cfg_nxt;
			rx_rate_r <= rx_rate_nxt;
			tx_rate_r <= tx_rate_nxt;
		end
	end

	assign cfg_rd = {6'h00, busy_r, line_std_r};
	assign txa_rd = {3'h0, txa_r};
	assign rxa_rd = {3'h0, rxa_r};
	assign chan_reset = busy_r;
	assign line_standard = std_eff_r;
	assign rx_cfg = rx_cfg_r;
	assign tx_cfg = tx_cfg_r;
	assign rx_rate = rx_rate_r;
	assign tx_rate = tx_rate_r;

endmodule

// ==== line_jitter_config.sv ====
// AXI4-Lite register bank for 22 line channels with jitter attenuator settings and a one-second timer interrupt.
`timescale 1ns/1ps
module line_jitter_config #(
	parameter int NUM_CHAN = line_jitter_pkg::NUM_CHAN
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [line_jitter_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [line_jitter_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic hw_standard_pin_mode,
	input wire logic hw_line_standard,
	input wire logic second_tick,
	input wire logic [NUM_CHAN-1:0][line_jitter_pkg::FILL_W-1:0] rx_fill,
	input wire logic [NUM_CHAN-1:0][line_jitter_pkg::FILL_W-1:0] tx_fill,
	output logic [NUM_CHAN-1:0] chan_reset,
	output logic [NUM_CHAN-1:0] line_standard,
	output line_jitter_pkg::atten_cfg_s [NUM_CHAN-1:0] rx_atten_cfg,
	output line_jitter_pkg::atten_cfg_s [NUM_CHAN-1:0] tx_atten_cfg,
	output line_jitter_pkg::rate_e [NUM_CHAN-1:0] rx_rate_adjust,
	output line_jitter_pkg::rate_e [NUM_CHAN-1:0] tx_rate_adjust,
	output logic irq
);

	typedef enum logic {
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} wr_state_e;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_e;

	wr_state_e wr_state_r;
	wr_state_e wr_state_nxt;
	rd_state_e rd_state_r;
	rd_state_e rd_state_nxt;
	logic aw_held_r;
	logic aw_held_nxt;
	logic w_held_r;
	logic w_held_nxt;
	logic [line_jitter_pkg::ADDR_W-1:0] awaddr_r;
	logic [line_jitter_pkg::ADDR_W-1:0] awaddr_nxt;
	logic [7:0] wdata_r;
	logic [7:0] wdata_nxt;
	logic wstrb0_r;
	logic wstrb0_nxt;
	logic [1:0] bresp_r;
	logic [1:0] bresp_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_r;
	logic [1:0] rresp_nxt;
	logic stat_r;
	logic stat_nxt;
	logic mask_r;
	logic mask_nxt;
	logic irq_r;
	logic irq_nxt;
	logic wr_fire;
	logic stat_clr;
	line_jitter_pkg::addr_dec_s wdec;
	line_jitter_pkg::addr_dec_s rdec;
	logic [1:0] pins_sync;
	logic [NUM_CHAN-1:0] wr_stb;
	logic [7:0] cfg_rd [NUM_CHAN];
	logic [7:0] txa_rd [NUM_CHAN];
	logic [7:0] rxa_rd [NUM_CHAN];

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation.
	line_sync3 #(
		.WIDTH(2)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({hw_line_standard, hw_standard_pin_mode}),
		.sync_out(pins_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// Channel slices.
	always_comb
	begin
		wdec = line_jitter_pkg::decode(awaddr_r);
		rdec = line_jitter_pkg::decode(s_axi_araddr);
		wr_fire = (wr_state_r == WR_IDLE) && aw_held_r && w_held_r;
		for (int i = 0; i < NUM_CHAN; i++)
			wr_stb[i] = wr_fire && wstrb0_r && wdec.hit_chan && (wdec.chan == 5'(i));
	end

	for (genvar g = 0; g < NUM_CHAN; g++)
	begin : g_chan
		line_chan_slice u_slice (
			.aclk(aclk),
			.aresetn(aresetn),
			.wr_stb(wr_stb[g]),
			.wr_reg(wdec.reg_sel),
			.wr_data(wdata_r),
			.pin_mode(pins_sync[0]),
			.pin_standard(pins_sync[1]),
			.rx_fill(rx_fill[g]),
			.tx_fill(tx_fill[g]),
			.cfg_rd(cfg_rd[g]),
			.txa_rd(txa_rd[g]),
			.rxa_rd(rxa_rd[g]),
			.chan_reset(chan_reset[g]),
			.line_standard(line_standard[g]),
			.rx_cfg(rx_atten_cfg[g]),
			.tx_cfg(tx_atten_cfg[g]),
			.rx_rate(rx_rate_adjust[g]),
			.tx_rate(tx_rate_adjust[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are taken in either order, then one response.
	always_comb
	begin
		wr_state_nxt = wr_state_r;
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb0_nxt = wstrb0_r;
		bresp_nxt = bresp_r;
		mask_nxt = mask_r;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata[7:0];
			wstrb0_nxt = s_axi_wstrb[0];
		end
		case (wr_state_r)
			WR_IDLE:
				if (wr_fire)
				begin
					aw_held_nxt = 1'b0;
					w_held_nxt = 1'b0;
					wr_state_nxt = WR_RESP;
					// The status register is cleared by reading, so a write to it is accepted and has no effect.
					if (wdec.hit_chan || wdec.hit_stat)
						bresp_nxt = line_jitter_pkg::AXI_OKAY;
					else if (wdec.hit_mask)
					begin
						bresp_nxt = line_jitter_pkg::AXI_OKAY;
						if (wstrb0_r)
							mask_nxt = wdata_r[line_jitter_pkg::TIMER_FLAG_BIT];
					end
					else
						bresp_nxt = line_jitter_pkg::AXI_SLVERR;
				end
			WR_RESP:
				if (s_axi_bready)
					wr_state_nxt = WR_IDLE;
			default:
				wr_state_nxt = WR_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel and the timer status flag.
	always_comb
	begin
		rd_state_nxt = rd_state_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		stat_clr = 1'b0;
		case (rd_state_r)
			RD_IDLE:
				if (s_axi_arvalid)
				begin
					rd_state_nxt = RD_DATA;
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = line_jitter_pkg::AXI_OKAY;
					if (rdec.hit_stat)
					begin
						rdata_nxt[line_jitter_pkg::TIMER_FLAG_BIT] = stat_r;
						stat_clr = 1'b1;
					end
					else if (rdec.hit_mask)
						rdata_nxt[line_jitter_pkg::TIMER_FLAG_BIT] = mask_r;
					else if (rdec.hit_chan && rdec.reg_sel == line_jitter_pkg::REG_CFG_IDX[1:0])
						rdata_nxt[7:0] = cfg_rd[rdec.chan];
					else if (rdec.hit_chan && rdec.reg_sel == line_jitter_pkg::REG_TXA_IDX[1:0])
						rdata_nxt[7:0] = txa_rd[rdec.chan];
					else if (rdec.hit_chan)
						rdata_nxt[7:0] = rxa_rd[rdec.chan];
					else
						rresp_nxt = line_jitter_pkg::AXI_SLVERR;
				end
			RD_DATA:
				if (s_axi_rready)
					rd_state_nxt = RD_IDLE;
			default:
				rd_state_nxt = RD_IDLE;
		endcase
		// A tick in the same cycle as the clearing read sets the flag again, so no second is lost.
		stat_nxt = (stat_r && !stat_clr) || second_tick;
		irq_nxt = stat_r && mask_r;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state_r <= WR_IDLE;
			rd_state_r <= RD_IDLE;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
			bresp_r <= line_jitter_pkg::AXI_OKAY;
			rdata_r <= 32'h0000_0000;
			rresp_r <= line_jitter_pkg::AXI_OKAY;
			stat_r <= 1'b0;
			mask_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			wr_state_r <= wr_state_nxt;
			rd_state_r <= rd_state_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			bresp_r <= bresp_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign s_axi_awready = (wr_state_r == WR_IDLE) && !aw_held_r;
	assign s_axi_wready = (wr_state_r == WR_IDLE) && !w_held_r;
	assign s_axi_bvalid = (wr_state_r == WR_RESP);
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = (rd_state_r == RD_IDLE);
	assign s_axi_rvalid = (rd_state_r == RD_DATA);
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign irq = irq_r;

endmodule

// ==== line_jitter_config_chk.sv ====
// Assertion checker bound to the line channel configuration block.
`timescale 1ns/1ps
module line_jitter_config_chk #(
	parameter int NUM_CHAN = 22
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [NUM_CHAN-1:0][line_jitter_pkg::FILL_W-1:0] rx_fill,
	input wire logic [NUM_CHAN-1:0][line_jitter_pkg::FILL_W-1:0] tx_fill,
	input wire logic [NUM_CHAN-1:0] chan_reset,
	input line_jitter_pkg::atten_cfg_s [NUM_CHAN-1:0] rx_atten_cfg,
	input line_jitter_pkg::atten_cfg_s [NUM_CHAN-1:0] tx_atten_cfg,
	input line_jitter_pkg::rate_e [NUM_CHAN-1:0] rx_rate_adjust,
	input line_jitter_pkg::rate_e [NUM_CHAN-1:0] tx_rate_adjust
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Counts how long channel 0 has been held in soft reset.
	always_comb
	begin
		cnt_nxt = chan_reset[0] ? cnt_r + 8'h01 : 8'h00;
	end

	always_ff @(posedge aclk)
	begin
		cnt_r <= aresetn ? cnt_nxt : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence srst_full;
		cnt_r == 8'h7D;
	endsequence

	sequence rx_steady;
		$stable(rx_fill[0]) && $stable(rx_atten_cfg[0]);
	endsequence

	sequence tx_steady;
		$stable(tx_fill[0]) && $stable(tx_atten_cfg[0]);
	endsequence

	srst_len_a: assert property (chan_reset[0] |-> cnt_r < 8'h7D)
		else $error("soft reset held too long");
	srst_end_a: assert property ($fell(chan_reset[0]) |-> srst_full)
		else $error("soft reset ended after a wrong count");
	rx_off_a: assert property (!rx_atten_cfg[0].enable |-> rx_atten_cfg[0] == '0)
		else $error("receive settings leak while disabled");
	tx_off_a: assert property (!tx_atten_cfg[0].enable |-> tx_atten_cfg[0] == '0)
		else $error("transmit settings leak while disabled");
	rx_slow_a: assert property (rx_atten_cfg[0].fill_limit && rx_fill[0] <= 8'h02 ##0 rx_steady
		|=> rx_rate_adjust[0] == line_jitter_pkg::RATE_SLOW)
		else $error("receive rate not slowed near empty");
	tx_fast_a: assert property (tx_atten_cfg[0].fill_limit && tx_fill[0] >= tx_atten_cfg[0].depth_bits - 8'h02
		##0 tx_steady |=> tx_rate_adjust[0] == line_jitter_pkg::RATE_FAST)
		else $error("transmit rate not sped up near full");
	rd_resv_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("reserved read bits not zero");
	rd_turn_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
endmodule

bind line_jitter_config line_jitter_config_chk #(.NUM_CHAN(NUM_CHAN)) chk (.*);

// ==== line_host_model.sv ====
// Host software model that reaches the registers as an AXI4-Lite master.
`timescale 1ns/1ps
module line_host_model (
	input wire logic aclk,
	output logic [12:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [12:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// Ready lines stay high, so every answer is taken at the edge it shows.
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
	end

	// Handshakes are judged at the falling edge, which sees the values of the next rising edge.
	task automatic wr(input logic [12:0] a, input logic [7:0] d, output logic [1:0] r);
		bit ha, hw, hb;
		hb = 0;
		r = 2'h3;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			if (hb) r = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
		end
		while (!hb);
	endtask

	task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ha, hr;
		hr = 0;
		r = 2'h3;
		d = 32'hFFFFFFFF;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid;
			if (hr) d = s_axi_rdata;
			if (hr) r = s_axi_rresp;
			@(posedge aclk);
			if (ha) s_axi_arvalid <= 1'b0;
		end
		while (!hr);
	endtask
endmodule

// ==== line_jitter_config_tb_top.sv ====
// Self-checking testbench of the line channel configuration block.
`timescale 1ns/1ps
module line_jitter_config_tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, second_tick;
	logic hw_standard_pin_mode, hw_line_standard;
	logic [12:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [21:0][7:0] rx_fill, tx_fill;
	logic [21:0] chan_reset, line_standard;
	line_jitter_pkg::atten_cfg_s [21:0] rx_atten_cfg, tx_atten_cfg;
	line_jitter_pkg::rate_e [21:0] rx_rate_adjust, tx_rate_adjust;
	logic [7:0] sh [22][4];
	logic [7:0] fills [8] = '{8'h02, 8'h03, 8'h1D, 8'h1E, 8'h3E, 8'h7E, 8'h7D, 8'hFF};
	logic [31:0] seed = 32'h00001D18;
	int miscompares = 0, check_count = 0, cyc = 0;

	line_jitter_config uut (.*);
	line_host_model host (.*);

	always #4 aclk = ~aclk;

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			miscompares++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [12:0] addr(input int ch, input int rg);
		return 13'(4 * ((ch == 0) ? 32'h000007C0 + rg : 32'h00000040 * (ch - 1) + rg));
	endfunction

	function automatic line_jitter_pkg::atten_cfg_s exp_cfg(input logic [7:0] r, input logic e1);
		line_jitter_pkg::atten_cfg_s c;
		c = '0;
		if (r[3])
		begin
			c.enable = 1'b1;
			c.fill_limit = r[4];
			c.depth_bits = r[2] ? 8'h20 : (r[1] ? 8'h40 : 8'h80);
			c.corner = line_jitter_pkg::corner_e'({r[0], e1});
		end
		return c;
	endfunction

	function automatic logic [1:0] exp_rate(input logic [7:0] r, input logic [7:0] f);
		logic [7:0] dep;
		dep = exp_cfg(r, 1'b0).depth_bits;
		if (!(r[3] && r[4])) return 2'h0;
		if (f >= dep - 8'h02) return 2'h2;
		return (f <= 8'h02) ? 2'h1 : 2'h0;
	endfunction

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] v;
		logic [7:0] d, f;
		logic e1;
		int ch, rg;
		{aclk, aresetn, second_tick, hw_standard_pin_mode, hw_line_standard, rx_fill, tx_fill} = '0;
		foreach (sh[i, j]) sh[i][j] = 8'h00;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (ch = 0; ch < 22; ch++)
			for (rg = 1; rg < 4; rg++)
			begin
				host.rd(addr(ch, rg), rv, rs);
				chk("reset value", rv, 32'h0);
			end
		$display("reset values done");
		for (int i = 0; i < 64; i++)
		begin
			v = rnd();
			ch = (i % 3 == 0) ? 0 : v[31:16] % 22;
			rg = 1 + v[15:12] % 3;
			d = {v[7:4], 4'(i)} & ((rg == 1) ? 8'hFD : 8'hFF);
			f = fills[i % 8];
			host.wr(addr(ch, rg), d, rs);
			chk("write resp", 32'(rs), 32'h0);
			sh[ch][rg] = d & ((rg == 1) ? 8'h01 : 8'h1F);
			hw_standard_pin_mode <= v[8];
			hw_line_standard <= v[9];
			rx_fill[ch] <= f;
			tx_fill[ch] <= f;
			repeat (8) @(posedge aclk);
			host.rd(addr(ch, rg), rv, rs);
			chk("readback", rv, 32'(sh[ch][rg]));
			e1 = v[8] ? v[9] : sh[ch][1][0];
			chk("line standard", 32'(line_standard[ch]), 32'(e1));
			chk("rx cfg", 32'(rx_atten_cfg[ch]), 32'(exp_cfg(sh[ch][3], e1)));
			chk("tx cfg", 32'(tx_atten_cfg[ch]), 32'(exp_cfg(sh[ch][2], e1)));
			chk("rx rate", 32'(rx_rate_adjust[ch]), 32'(exp_rate(sh[ch][3], f)));
			chk("tx rate", 32'(tx_rate_adjust[ch]), 32'(exp_rate(sh[ch][2], f)));
		end
		$display("random config done");
		hw_standard_pin_mode <= 1'b0;
		host.wr(addr(0, 3), 8'h1F, rs);
		host.wr(addr(0, 1), 8'h01, rs);
		host.wr(addr(0, 1), 8'h03, rs);
		host.rd(addr(0, 1), rv, rs);
		chk("reset busy", rv, 32'h3);
		chk("other channel", 32'(chan_reset[1]), 32'h0);
		for (int n = 0; n < 300 && chan_reset[0] !== 1'b0; n++) @(posedge aclk);
		host.rd(addr(0, 1), rv, rs);
		chk("reset cleared", rv, 32'h1);
		host.rd(addr(0, 3), rv, rs);
		chk("rx cleared", rv, 32'h0);
		chk("standard kept", 32'(line_standard[0]), 32'h1);
		host.s_axi_wstrb <= 4'hE;
		host.wr(addr(0, 3), 8'h1F, rs);
		host.s_axi_wstrb <= 4'hF;
		host.rd(addr(0, 3), rv, rs);
		chk("strobe off", rv, 32'h0);
		$display("soft reset done");
		for (int i = 0; i < 2; i++)
		begin
			host.wr(i ? addr(22, 1) : 13'h0010, 8'h01, rs);
			chk("unmapped write", 32'(rs), 32'h2);
			host.rd(i ? addr(22, 1) : 13'h0010, rv, rs);
			chk("unmapped read", {rv[29:0], rs}, 32'h2);
		end
		$display("unmapped done");
		for (int i = 1; i >= 0; i--)
		begin
			host.wr(13'h0F80, 8'(i), rs);
			second_tick <= 1'b1;
			@(posedge aclk);
			second_tick <= 1'b0;
			repeat (4) @(posedge aclk);
			chk("irq", 32'(irq), 32'(i));
			host.rd(13'h0F00, rv, rs);
			chk("timer flag", rv, 32'h1);
			repeat (4) @(posedge aclk);
			chk("irq clear", 32'(irq), 32'h0);
			host.rd(13'h0F00, rv, rs);
			chk("flag clear", rv, 32'h0);
		end
		$display("interrupt done");
		end_sim();
	end
endmodule
